// *** verilog/csi_debug_pkg.sv ***
// Shared constants for the CSI-2 debug frame and line counter bank
package csi_debug_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] BANK_BASE      = 8'h90;
  localparam logic [7:0] BANK_MASK      = 8'hf0;
  localparam logic [7:0] PORT0_FRAMES_UPPER     = 8'h90;
  localparam logic [7:0] PORT0_FRAMES_LOWER     = 8'h91;
  localparam logic [7:0] PORT0_BAD_FRAMES_UPPER = 8'h92;
  localparam logic [7:0] PORT0_BAD_FRAMES_LOWER = 8'h93;
  localparam logic [7:0] PORT0_LINES_UPPER      = 8'h94;
  localparam logic [7:0] PORT0_LINES_LOWER      = 8'h95;
  localparam logic [7:0] PORT0_BAD_LINES_UPPER  = 8'h96;
  localparam logic [7:0] PORT0_BAD_LINES_LOWER  = 8'h97;
  localparam logic [7:0] PORT1_FRAMES_UPPER     = 8'h98;
  localparam logic [7:0] PORT1_FRAMES_LOWER     = 8'h99;
  localparam logic [7:0] PORT1_LINES_UPPER      = 8'h9c;

  // Address bit picking the lower (snapshot) byte, and the index field
  localparam int          LOWER_BIT      = 0;
  localparam int          INDEX_LSB      = 1;
  localparam int          INDEX_W        = 3;
  localparam int          NUM_TALLIES    = 8;
  localparam int          KINDS_PER_PORT = 4;

  // Tally kinds within one port
  localparam int          KIND_FRAMES     = 0;
  localparam int          KIND_BAD_FRAMES = 1;
  localparam int          KIND_LINES      = 2;
  localparam int          KIND_BAD_LINES  = 3;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int          TALLY_W        = 16;
  localparam int          BYTE_W         = 8;
  localparam logic [15:0] TALLY_RESET    = 16'h0000;
  localparam logic [15:0] TALLY_ONE      = 16'h0001;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic [7:0]  UNMAPPED_VALUE = 8'h00;

  // ----------------------------------------------------------------
  // Event word carried through the FIFO
  // ----------------------------------------------------------------
  localparam int          EVT_W          = 4;
  localparam int          EVT_ERR_BIT    = 0;
  localparam int          EVT_LINE_BIT   = 1;
  localparam int          EVT_FRAME_BIT  = 2;
  localparam int          EVT_PORT_BIT   = 3;
  localparam int          FIFO_DEPTH     = 16;

endpackage : csi_debug_pkg

// *** verilog/event_fifo.sv ***
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module event_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      rd_ptr_q;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  // ----------------------------------------------------------------
  // Flags: extra pointer bit tells full from empty
  // ----------------------------------------------------------------
  assign empty     = (wr_ptr_q == rd_ptr_q);
  assign full      = (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]) && (wr_ptr_q[AW] != rd_ptr_q[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = mem[rd_ptr_q[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
    end else if (push) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_ptr_q <= '0;
    end else if (pop) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

endmodule : event_fifo

// *** verilog/snap_tally.sv ***
// One 16-bit tally; capture snapshots its low byte and clears the whole count
`timescale 1ns/100ps
module snap_tally (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       inc,
  input  wire logic       capture,
  output logic [15:0]     count,
  output logic [7:0]      snapshot
);

  logic [15:0] count_q;
  logic [7:0]  snap_q;

  assign count    = count_q;
  assign snapshot = snap_q;

  // Increment wraps; a concurrent increment survives the clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      count_q <= csi_debug_pkg::TALLY_RESET;
    end else if (capture) begin
      count_q <= inc ? csi_debug_pkg::TALLY_ONE : csi_debug_pkg::TALLY_RESET;
    end else if (inc) begin
      count_q <= count_q + csi_debug_pkg::TALLY_ONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      snap_q <= csi_debug_pkg::BYTE_RESET;
    end else if (capture) begin
      snap_q <= count_q[csi_debug_pkg::BYTE_W-1:0];
    end
  end

endmodule : snap_tally

// *** verilog/csi_debug_frame_line_counters.sv ***
// Frame and line diagnostic tallies for two CSI-2 output ports
`timescale 1ns/100ps

module csi_debug_frame_line_counters (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       evt_valid,
  output logic            evt_ready,
  input  wire logic       evt_port,
  input  wire logic       evt_frame_end,
  input  wire logic       evt_line_end,
  input  wire logic       evt_pkt_err,
  input  wire logic       rd_en,
  input  wire logic [7:0] rd_addr,
  output logic [7:0]      rd_data,
  output logic            rd_valid
);

  localparam int NT = csi_debug_pkg::NUM_TALLIES;
  localparam int KP = csi_debug_pkg::KINDS_PER_PORT;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic in_bank(input logic [7:0] addr);
    return (addr & csi_debug_pkg::BANK_MASK) == csi_debug_pkg::BANK_BASE;
  endfunction : in_bank

  function automatic logic [2:0] tally_index(input logic [7:0] addr);
    return addr[csi_debug_pkg::INDEX_LSB +: csi_debug_pkg::INDEX_W];
  endfunction : tally_index

  // ----------------------------------------------------------------
  // Event FIFO
  // ----------------------------------------------------------------
  logic [csi_debug_pkg::EVT_W-1:0] evt_word;
  logic [csi_debug_pkg::EVT_W-1:0] fifo_word;
  logic                            fifo_valid;
  logic                            drain_ready;
  logic                            take;

  assign evt_word = {evt_port, evt_frame_end, evt_line_end, evt_pkt_err};

  // Draining pauses on register reads so a capture never meets an update
  assign drain_ready = !rd_en;
  assign take        = fifo_valid && drain_ready;

  event_fifo #(
    .WIDTH (csi_debug_pkg::EVT_W),
    .DEPTH (csi_debug_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (evt_valid),
    .in_ready  (evt_ready),
    .in_data   (evt_word),
    .out_valid (fifo_valid),
    .out_ready (drain_ready),
    .out_data  (fifo_word)
  );

  // ----------------------------------------------------------------
  // Per-port error tracking
  // ----------------------------------------------------------------
  logic       ev_port;
  logic       ev_frame;
  logic       ev_line;
  logic       ev_err;
  logic [1:0] line_bad_q;
  logic [1:0] frame_bad_q;
  logic       line_bad;
  logic       frame_bad;

  assign ev_port   = fifo_word[csi_debug_pkg::EVT_PORT_BIT];
  assign ev_frame  = fifo_word[csi_debug_pkg::EVT_FRAME_BIT];
  assign ev_line   = fifo_word[csi_debug_pkg::EVT_LINE_BIT];
  assign ev_err    = fifo_word[csi_debug_pkg::EVT_ERR_BIT];
  // An error in the closing event still taints its line and frame
  assign line_bad  = line_bad_q[ev_port] || ev_err;
  assign frame_bad = frame_bad_q[ev_port] || ev_err;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      line_bad_q <= '0;
    end else if (take) begin
      line_bad_q[ev_port] <= ev_line ? 1'b0 : line_bad;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frame_bad_q <= '0;
    end else if (take) begin
      frame_bad_q[ev_port] <= ev_frame ? 1'b0 : frame_bad;
    end
  end

  // ----------------------------------------------------------------
  // Tallies: index is port * 4 + kind
  // ----------------------------------------------------------------
  logic [NT-1:0] inc;
  logic [NT-1:0] capture;
  logic [15:0]   count   [NT];
  logic [7:0]    snap    [NT];
  logic          rd_hit;
  logic          rd_lower;
  logic [2:0]    rd_idx;

  assign rd_hit   = in_bank(rd_addr);
  assign rd_lower = rd_addr[csi_debug_pkg::LOWER_BIT];
  assign rd_idx   = tally_index(rd_addr);

  always_comb begin
    inc = '0;
    if (take) begin
      inc[int'(ev_port) * KP + csi_debug_pkg::KIND_FRAMES]     = ev_frame;
      inc[int'(ev_port) * KP + csi_debug_pkg::KIND_BAD_FRAMES] = ev_frame && frame_bad;
      inc[int'(ev_port) * KP + csi_debug_pkg::KIND_LINES]      = ev_line;
      inc[int'(ev_port) * KP + csi_debug_pkg::KIND_BAD_LINES]  = ev_line && line_bad;
    end
  end

  // Only an upper-byte read captures and clears
  always_comb begin
    capture = '0;
    if (rd_en && rd_hit && !rd_lower) begin
      capture[rd_idx] = 1'b1;
    end
  end

  for (genvar i = 0; i < NT; i++) begin : g_tally
    snap_tally u_tally (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .inc      (inc[i]),
      .capture  (capture[i]),
      .count    (count[i]),
      .snapshot (snap[i])
    );
  end

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  logic [7:0] rd_data_q;
  logic       rd_valid_q;

  assign rd_data  = rd_data_q;
  assign rd_valid = rd_valid_q;

  // Lower byte is only coherent if the upper byte was read first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data_q <= csi_debug_pkg::BYTE_RESET;
    end else if (rd_en) begin
      if (!rd_hit) begin
        rd_data_q <= csi_debug_pkg::UNMAPPED_VALUE;
      end else if (rd_lower) begin
        rd_data_q <= snap[rd_idx];
      end else begin
        rd_data_q <= count[rd_idx][csi_debug_pkg::TALLY_W-1:csi_debug_pkg::BYTE_W];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_en;
    end
  end

endmodule : csi_debug_frame_line_counters

// *** dv/csi_debug_frame_line_counters_assertions.sv ***
// Port-level checks for the debug tally bank
`timescale 1ns/100ps
module csi_debug_frame_line_counters_assertions (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       evt_valid,
  input wire logic       evt_ready,
  input wire logic       evt_port,
  input wire logic       evt_frame_end,
  input wire logic       evt_line_end,
  input wire logic       evt_pkt_err,
  input wire logic       rd_en,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic       rd_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  property p_answer;
    rd_en |=> rd_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  property p_quiet;
    !rd_en |=> !rd_valid && $stable(rd_data);
  endproperty
  a_quiet: assert property (p_quiet) else $error("read data moved without read");
  property p_reset;
    $fell(rst) |-> !rd_valid && rd_data == 8'h00 && evt_ready;
  endproperty
  a_reset: assert property (p_reset) else $error("bad state after reset");
  // Drain stalls while reading, so a repeated upper read sees the cleared tally
  property p_clear;
    rd_en && rd_addr[7:4] == 4'h9 && !rd_addr[0] ##1 rd_en && $stable(rd_addr) |=> rd_data == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("upper read did not clear");
  // Back-to-back lower reads of one tally return the same snapshot
  property p_snap;
    rd_en && rd_addr[7:4] == 4'h9 && rd_addr[0] ##1 rd_en && $stable(rd_addr) |=> $stable(rd_data);
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot changed");
  property p_unmapped;
    rd_en && rd_addr[7:4] != 4'h9 |=> rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // ----------------------------------------------------------------
  // Event buffer
  // ----------------------------------------------------------------
  property p_drain;
    !evt_ready && !rd_en |=> evt_ready;
  endproperty
  a_drain: assert property (p_drain) else $error("full buffer did not drain");
  property p_stall;
    !evt_ready && rd_en |=> !evt_ready;
  endproperty
  a_stall: assert property (p_stall) else $error("buffer drained during read");
endmodule : csi_debug_frame_line_counters_assertions

bind csi_debug_frame_line_counters csi_debug_frame_line_counters_assertions i_csi_debug_frame_line_counters_assertions (
  .ref_clk, .rst, .evt_valid, .evt_ready, .evt_port, .evt_frame_end,
  .evt_line_end, .evt_pkt_err, .rd_en, .rd_addr, .rd_data, .rd_valid);

// *** dv/csi_debug_frame_line_counters_bench.sv ***
// Self-checking bench for the debug tally bank
`timescale 1ns/100ps
module csi_debug_frame_line_counters_bench;
  logic       ref_clk, rst, evt_valid, evt_ready, evt_port, evt_frame_end, evt_line_end;
  logic       evt_pkt_err, rd_en, rd_valid, saw_full;
  logic [7:0] rd_addr, rd_data;
  int         cnt [8];
  int         snap [8];
  bit         lerr [2];
  bit         ferr [2];
  int         bad_count, num_checks, seed;
  int         taken;

  csi_debug_frame_line_counters i_csi_debug_frame_line_counters (
    .ref_clk, .rst, .evt_valid, .evt_ready, .evt_port, .evt_frame_end,
    .evt_line_end, .evt_pkt_err, .rd_en, .rd_addr, .rd_data, .rd_valid);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) if (evt_ready === 1'b0) saw_full = 1'b1;

  // ----------------------------------------------------------------
  // Tasks, entered at a falling edge
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic rd(input logic [7:0] a);
    logic [2:0] i;
    logic [7:0] e;
    i = a[3:1];
    e = 8'h00;
    if (a[7:4] == 4'h9 && !a[0]) begin
      e = 8'(cnt[i] >> 8);
      snap[i] = cnt[i] % 256;
      cnt[i] = 0;
    end else if (a[7:4] == 4'h9) begin
      e = 8'(snap[i]);
    end
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge ref_clk);
    check({7'h00, rd_valid}, 8'h01);
    check(rd_data, e);
  endtask : rd

  // Model is updated at the taking edge; reads wait for the buffer to drain
  task automatic send(input logic [3:0] ev);
    int p;
    p = ev[3] * 4;
    evt_valid = 1'b1;
    {evt_port, evt_frame_end, evt_line_end, evt_pkt_err} = ev;
    while (evt_ready !== 1'b1) @(negedge ref_clk);
    @(negedge ref_clk);
    taken++;
    if (ev[0]) begin
      lerr[ev[3]] = 1'b1;
      ferr[ev[3]] = 1'b1;
    end
    if (ev[1]) begin
      cnt[p + 2] = (cnt[p + 2] + 1) % 65536;
      if (lerr[ev[3]]) cnt[p + 3] = (cnt[p + 3] + 1) % 65536;
      lerr[ev[3]] = 1'b0;
    end
    if (ev[2]) begin
      cnt[p] = (cnt[p] + 1) % 65536;
      if (ferr[ev[3]]) cnt[p + 1] = (cnt[p + 1] + 1) % 65536;
      ferr[ev[3]] = 1'b0;
    end
  endtask : send

  task automatic idle(input int n);
    rd_en = 1'b0;
    evt_valid = 1'b0;
    repeat (n) @(negedge ref_clk);
  endtask : idle

  task automatic read_all;
    logic [7:0] up;
    for (int i = 0; i < 8; i++) begin
      up = 8'h90 + 8'(2 * i);
      rd(up);
      rd(up + 8'h01);
      rd(up + 8'h01);
      rd(up);
      rd(up);
    end
    idle(2);
  endtask : read_all

  task automatic stop_test;
    $display("checks=%0d bad=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 94;
    saw_full = 1'b0;
    rst = 1'b1;
    rd_addr = 8'h00;
    evt_port = 1'b0;
    evt_frame_end = 1'b0;
    evt_line_end = 1'b0;
    evt_pkt_err = 1'b0;
    idle(8);
    rst = 1'b0;
    for (int a = 8'h8f; a <= 8'ha0; a++) rd(8'(a));
    // Held reads stall the drain, so random events back up until refused
    fork
      begin
        repeat (24) rd(8'ha0);
        // A stalled drain must accept exactly one buffer's worth
        check(8'(taken), 8'h10);
        rd_en = 1'b0;
      end
      begin
        repeat (30) send(4'($random(seed)));
      end
    join
    check({7'h00, saw_full}, 8'h01);
    idle(30);
    read_all();
    // Past one full wrap, leaving a nonzero upper byte
    repeat (65800) send(4'b1110);
    idle(20);
    read_all();
    stop_test();
  end

  // About 66k cycles expected
  initial begin
    #900us;
    bad_count++;
    stop_test();
  end
endmodule : csi_debug_frame_line_counters_bench
